// ==== verification/plc_master_model.sv ====
// fieldbus master model that issues register writes
`timescale 1ns/100ps
module plc_master_model
  import web_guide_pkg::*;
(
  input wire logic i_core_clk,
  output wr_req_type o_wr
);
  initial o_wr = '0;
  // =====================================================
  // one write, launched and dropped on falling edges
  task automatic send(input logic [1:0] sel, input logic [15:0] data);
    @(negedge i_core_clk);
    o_wr = '{en: 1'b1, sel: sel, data: data};
    @(negedge i_core_clk);
    o_wr.en = 1'b0;
    // idle bus never repeats the old word
    o_wr.data = ~data;
  endtask
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the remote command registers
`timescale 1ns/100ps
module testbench;
  import web_guide_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  wr_req_type wr;
  logic [15:0] cmd, ofs;
  logic rem, am, jl, jr, cs, ge;
  logic signed [15:0] gp;
  logic [6:0] spd, acc;
  int bad_count = 0;
  int checks_done = 0;
  always #5 i_core_clk = ~i_core_clk;
  plc_master_model plc_master_model_i (.i_core_clk(i_core_clk),
    .o_wr(wr));
  web_guide_remote_command_regs web_guide_remote_command_regs_i (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_wr(wr),
    .o_cmd_word(cmd), .o_offset_word(ofs), .o_remote_active(rem),
    .o_auto_mode(am), .o_jog_left(jl), .o_jog_right(jr),
    .o_center_start(cs), .o_gross_enable(ge), .o_guide_point(gp),
    .o_speed(spd), .o_accel(acc));
  // =====================================================
  // compare, report and close
  task automatic chk(input string n, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wc(input logic [15:0] d);
    plc_master_model_i.send(SEL_CMD, d);
  endtask
  task automatic wr_to(input logic [1:0] s, input logic [15:0] d);
    plc_master_model_i.send(s, d);
  endtask
  // flags packed as remote, auto, left, right, centre, gross
  task automatic fl(input logic [5:0] e);
    chk("flags", {10'h000, rem, am, jl, jr, cs, ge}, e);
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  // =====================================================
  // hang guard
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  // =====================================================
  // main sequence
  initial begin
    repeat (16) @(negedge i_core_clk);
    i_srst = 1'b0;
    fl(6'h00);
    chk("gp", gp, 16'h0000);
    chk("cmd", cmd, CMD_RESET);
    done("reset");
    wc(16'hFEFF);
    chk("cmd", cmd, 16'h3E00);
    fl(6'h00);
    wc(16'h0000);
    done("local");
    wc(16'h0500);
    fl(6'h28);
    wc(16'h0900);
    fl(6'h24);
    wc(16'h0100);
    fl(6'h20);
    wc(16'h1100);
    fl(6'h22);
    @(negedge i_core_clk);
    fl(6'h20);
    wc(16'h1100);
    fl(6'h20);
    repeat (3) @(negedge i_core_clk);
    chk("cmd", cmd, 16'h1100);
    done("manual");
    wc(16'h0300);
    fl(6'h30);
    wc(16'h0700);
    chk("gp", gp, 16'(-STEP_COUNTS));
    wc(16'h0700);
    chk("gp", gp, 16'(-STEP_COUNTS));
    wc(16'h0300);
    chk("gp", gp, 16'(-STEP_COUNTS));
    wc(16'h0B00);
    chk("gp", gp, 16'h0000);
    wc(16'h0B00);
    wc(16'h0300);
    wc(16'h0B00);
    wc(16'h1300);
    chk("gp", gp, 16'h0000);
    done("auto");
    wc(16'h0300);
    wr_to(SEL_OFFSET, 16'h0064);
    chk("ofs", ofs, 16'h0064);
    chk("gp", gp, 16'h0000);
    wc(16'h2300);
    fl(6'h31);
    wr_to(SEL_OFFSET, 16'h0064);
    chk("gp", gp, 16'h0064);
    wr_to(SEL_OFFSET, 16'hFF9C);
    chk("gp", gp, 16'hFF9C);
    wr_to(SEL_OFFSET, 16'(GP_LIMIT - 1));
    wc(16'h2B00);
    chk("gp", gp, 16'(GP_LIMIT));
    wc(16'h2300);
    wc(16'h2B00);
    chk("gp", gp, 16'(GP_LIMIT));
    wr_to(SEL_OFFSET, 16'h8000);
    chk("gp", gp, 16'(-GP_LIMIT));
    wc(16'h0200);
    fl(6'h00);
    done("offset");
    wr_to(SEL_SPEED, 16'h3200);
    chk("speed", spd, SETTING_RESET);
    wr_to(SEL_SPEED, 16'hE400);
    chk("speed", spd, SETTING_MAX);
    wr_to(SEL_SPEED, 16'hE500);
    chk("speed", spd, SETTING_MAX);
    wr_to(SEL_ACCEL, 16'h0032);
    chk("accel", acc, SETTING_RESET);
    wr_to(SEL_ACCEL, 16'h00E4);
    chk("accel", acc, SETTING_MAX);
    wr_to(SEL_ACCEL, 16'h00E5);
    chk("accel", acc, SETTING_MAX);
    chk("speed", spd, SETTING_MAX);
    done("settings");
    @(negedge i_core_clk);
    i_srst = 1'b1;
    repeat (2) @(negedge i_core_clk);
    i_srst = 1'b0;
    fl(6'h00);
    chk("gp", gp, 16'h0000);
    chk("speed", spd, SETTING_RESET);
    chk("accel", acc, SETTING_RESET);
    chk("ofs", ofs, OFFSET_RESET);
    wc(16'h0500);
    fl(6'h28);
    done("reset again");
    finish_test();
  end
endmodule

// ==== verilog/web_guide_pkg.sv ====
// constants and types for the web guide remote command registers
package web_guide_pkg;

  // =====================================================
  // register select codes on the write port
  localparam logic [1:0] SEL_CMD = 2'h0;
  localparam logic [1:0] SEL_OFFSET = 2'h1;
  localparam logic [1:0] SEL_SPEED = 2'h2;
  localparam logic [1:0] SEL_ACCEL = 2'h3;

  // =====================================================
  // field layouts and reset values
  localparam int SPEED_EN_BIT = 15;
  localparam int SPEED_VAL_LSB = 8;
  localparam int ACCEL_EN_BIT = 7;
  localparam int ACCEL_VAL_LSB = 0;
  localparam logic [6:0] SETTING_MAX = 7'h64;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [6:0] SETTING_RESET = 7'h00;

  // =====================================================
  // distances, one count of guide point is 0.0635 mm
  localparam int COUNT_NM = 63500;
  localparam int STEP_NM = 254000;
  localparam int MARGIN_NM = 3175000;
  localparam int STEP_COUNTS = STEP_NM / COUNT_NM;
  localparam int MARGIN_COUNTS = (MARGIN_NM + COUNT_NM - 1) / COUNT_NM;
  // half window width in counts depends on the sensor fitted
  localparam int WINDOW_HALF_COUNTS = 1000;
  localparam int GP_LIMIT = WINDOW_HALF_COUNTS - MARGIN_COUNTS;

  // =====================================================
  // command word layout, msb first
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic gross_en;
    logic center;
    logic right;
    logic left;
    logic auto_mode;
    logic remote;
    logic [7:0] rsvd_lo;
  } cmd_type;

  // write request from the fieldbus side
  typedef struct packed {
    logic en;
    logic [1:0] sel;
    logic [15:0] data;
  } wr_req_type;

endpackage

// ==== verilog/web_guide_remote_command_regs.sv ====
// remote command register set of the web guide controller
`timescale 1ns/100ps

// How it works
// - reserved command bits stored zero, no effect
// - bit 8 hands control to remote
// - bit 9 selects manual or automatic
// - manual: bit 10 level jogs left
// - auto: bit 10 rise steps point down
// - manual: bit 11 level jogs right
// - auto: bit 11 rise steps point up
// - command bits never changed by hardware
// - guide point clamped keeping margin
// - manual: bit 12 rise starts centering
// - auto: bit 12 rise centres point
// - auto: writing zero only clears bit
// - bit 13 gates offset writes onto the point, word always stored
// - offset is signed 16-bit from middle
// - positive offset right, negative left
// - one offset count is 0.0635 mm
// - speed taken only with bit 15
// - acceleration taken only with bit 7
module web_guide_remote_command_regs
  import web_guide_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire wr_req_type i_wr,
  output logic [15:0] o_cmd_word,
  output logic [15:0] o_offset_word,
  output logic o_remote_active,
  output logic o_auto_mode,
  output logic o_jog_left,
  output logic o_jog_right,
  output logic o_center_start,
  output logic o_gross_enable,
  output logic signed [15:0] o_guide_point,
  output logic [6:0] o_speed,
  output logic [6:0] o_accel
);

  // =====================================================
  // state
  cmd_type cmd_reg, cmd_next;
  logic [15:0] offset_reg, offset_next;
  logic signed [15:0] gp_reg, gp_next;
  logic [6:0] speed_reg, speed_next;
  logic [6:0] accel_reg, accel_next;
  logic jog_left_reg, jog_left_next;
  logic jog_right_reg, jog_right_next;
  logic center_reg, center_next;
  logic remote_reg, remote_next;
  logic auto_reg, auto_next;
  logic gross_reg, gross_next;

  function automatic logic signed [15:0] clamp_gp(
    input logic signed [17:0] v
  );
    logic signed [17:0] lim;
    lim = 18'(GP_LIMIT);
    if (v > lim) begin
      clamp_gp = 16'(lim);
    end else if (v < -lim) begin
      clamp_gp = 16'(-lim);
    end else begin
      clamp_gp = 16'(v);
    end
  endfunction

  // =====================================================
  // next state
  always_comb begin
    cmd_type wcmd;
    logic wr_cmd;
    logic rise_l, rise_r, rise_c;
    logic signed [17:0] delta;
    wcmd = cmd_type'(i_wr.data);
    wr_cmd = i_wr.en && (i_wr.sel == SEL_CMD);
    rise_l = wr_cmd && wcmd.left && !cmd_reg.left;
    rise_r = wr_cmd && wcmd.right && !cmd_reg.right;
    rise_c = wr_cmd && wcmd.center && !cmd_reg.center;
    delta = 18'sh00000;
    cmd_next = cmd_reg;
    offset_next = offset_reg;
    gp_next = gp_reg;
    speed_next = speed_reg;
    accel_next = accel_reg;
    center_next = 1'b0;
    // reserved bits never reach the guide
    wcmd.rsvd_hi = 2'h0;
    wcmd.rsvd_lo = 8'h00;
    // only writes move command bits, never position feedback
    if (wr_cmd) begin
      cmd_next = wcmd;
    end
    if (cmd_next.remote) begin
      if (cmd_next.auto_mode) begin
        // a zero write only clears the stored bit
        if (rise_r) begin
          delta = delta + 18'(STEP_COUNTS);
        end
        if (rise_l) begin
          delta = delta - 18'(STEP_COUNTS);
        end
        if (rise_c) begin
          gp_next = 16'sh0000;
        end else begin
          gp_next = clamp_gp(18'(gp_reg) + delta);
        end
      end else begin
        center_next = rise_c;
      end
    end
    if (i_wr.en && (i_wr.sel == SEL_OFFSET)) begin
      offset_next = i_wr.data;
      // counts are 0.0635 mm from middle, sign gives the side
      if (cmd_reg.remote && cmd_reg.gross_en) begin
        gp_next = clamp_gp(18'(signed'(i_wr.data)));
      end
    end
    if (i_wr.en && (i_wr.sel == SEL_SPEED) && i_wr.data[SPEED_EN_BIT]
        && (i_wr.data[SPEED_VAL_LSB +: 7] <= SETTING_MAX)) begin
      speed_next = i_wr.data[SPEED_VAL_LSB +: 7];
    end
    if (i_wr.en && (i_wr.sel == SEL_ACCEL) && i_wr.data[ACCEL_EN_BIT]
        && (i_wr.data[ACCEL_VAL_LSB +: 7] <= SETTING_MAX)) begin
      accel_next = i_wr.data[ACCEL_VAL_LSB +: 7];
    end
    // local operator keeps control unless remote is set
    remote_next = cmd_next.remote;
    auto_next = cmd_next.remote && cmd_next.auto_mode;
    gross_next = cmd_next.remote && cmd_next.gross_en;
    jog_left_next = cmd_next.remote && !cmd_next.auto_mode
                    && cmd_next.left;
    jog_right_next = cmd_next.remote && !cmd_next.auto_mode
                     && cmd_next.right;
  end

  // =====================================================
  // registers
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cmd_reg <= cmd_type'(CMD_RESET);
      offset_reg <= OFFSET_RESET;
      gp_reg <= 16'sh0000;
      speed_reg <= SETTING_RESET;
      accel_reg <= SETTING_RESET;
      jog_left_reg <= 1'b0;
      jog_right_reg <= 1'b0;
      center_reg <= 1'b0;
      remote_reg <= 1'b0;
      auto_reg <= 1'b0;
      gross_reg <= 1'b0;
    end else begin
      cmd_reg <= cmd_next;
      offset_reg <= offset_next;
      gp_reg <= gp_next;
      speed_reg <= speed_next;
      accel_reg <= accel_next;
      jog_left_reg <= jog_left_next;
      jog_right_reg <= jog_right_next;
      center_reg <= center_next;
      remote_reg <= remote_next;
      auto_reg <= auto_next;
      gross_reg <= gross_next;
    end
  end

  assign o_cmd_word = cmd_reg;
  assign o_offset_word = offset_reg;
  assign o_remote_active = remote_reg;
  assign o_auto_mode = auto_reg;
  assign o_jog_left = jog_left_reg;
  assign o_jog_right = jog_right_reg;
  assign o_center_start = center_reg;
  assign o_gross_enable = gross_reg;
  assign o_guide_point = gp_reg;
  assign o_speed = speed_reg;
  assign o_accel = accel_reg;

  // =====================================================
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  logic wr_cmd_c;
  assign wr_cmd_c = i_wr.en && (i_wr.sel == SEL_CMD);

  a_reserved_zero: assert property (
    o_cmd_word[15:14] == 2'h0 && o_cmd_word[7:0] == 8'h00)
    else $error("reserved command bits stored");

  a_local_no_jog: assert property (
    !o_remote_active |-> !o_jog_left && !o_jog_right && !o_auto_mode)
    else $error("motion output while local");

  a_jog_left_level: assert property (
    wr_cmd_c && i_wr.data[8] && !i_wr.data[9] && i_wr.data[10]
    |=> o_jog_left [*1] ##0 o_remote_active)
    else $error("jog left not asserted");

  a_step_down: assert property (
    wr_cmd_c && i_wr.data[8] && i_wr.data[9] && i_wr.data[10]
    && !o_cmd_word[10] && !i_wr.data[11] && !i_wr.data[12]
    && (o_guide_point > -GP_LIMIT + STEP_COUNTS)
    |=> o_guide_point == $past(o_guide_point) - STEP_COUNTS)
    else $error("guide point step down wrong");

  a_gp_clamped: assert property (
    o_guide_point <= GP_LIMIT && o_guide_point >= -GP_LIMIT)
    else $error("guide point outside limit");

  a_center_auto: assert property (
    wr_cmd_c && i_wr.data[8] && i_wr.data[9] && i_wr.data[12]
    && !o_cmd_word[12] |=> o_guide_point == 16'sh0000)
    else $error("guide point not centred");

  a_center_pulse: assert property (
    o_center_start |=> !o_center_start)
    else $error("centering start longer than one cycle");

  a_zero_no_move: assert property (
    wr_cmd_c && i_wr.data[9] && i_wr.data[12:10] == 3'h0
    |=> o_guide_point == $past(o_guide_point))
    else $error("zero write moved guide point");

  a_offset_gated: assert property (
    i_wr.en && i_wr.sel == SEL_OFFSET && !o_gross_enable
    |=> $stable(o_guide_point))
    else $error("offset applied while disabled");

  a_cmd_hold: assert property (
    !wr_cmd_c |=> $stable(o_cmd_word))
    else $error("command word changed without write");

  a_speed_gate: assert property (
    i_wr.en && i_wr.sel == SEL_SPEED && !i_wr.data[15]
    |=> $stable(o_speed))
    else $error("speed taken without enable");

  a_accel_range: assert property (
    o_accel <= SETTING_MAX && o_speed <= SETTING_MAX)
    else $error("setting above maximum");

  a_remote_follows: assert property (
    wr_cmd_c |=> o_remote_active == $past(i_wr.data[8]))
    else $error("remote flag does not follow write");

  a_auto_follows: assert property (
    wr_cmd_c
    |=> o_auto_mode == ($past(i_wr.data[8]) && $past(i_wr.data[9])))
    else $error("auto mode does not follow write");

  a_jog_right_level: assert property (
    wr_cmd_c && i_wr.data[8] && !i_wr.data[9] && i_wr.data[11]
    |=> o_jog_right && !o_auto_mode)
    else $error("jog right not asserted");

  a_step_up: assert property (
    wr_cmd_c && i_wr.data[8] && i_wr.data[9] && i_wr.data[11]
    && !o_cmd_word[11] && !i_wr.data[10] && !i_wr.data[12]
    && (o_guide_point < GP_LIMIT - STEP_COUNTS)
    |=> o_guide_point == $past(o_guide_point) + STEP_COUNTS)
    else $error("guide point step up wrong");

  a_center_manual: assert property (
    wr_cmd_c && i_wr.data[8] && !i_wr.data[9] && i_wr.data[12]
    && !o_cmd_word[12] |=> o_center_start)
    else $error("centering not started");

  a_local_ignored: assert property (
    wr_cmd_c && !i_wr.data[8]
    |=> $stable(o_guide_point) && !o_center_start)
    else $error("command acted on while local");

  a_offset_stored: assert property (
    i_wr.en && i_wr.sel == SEL_OFFSET
    |=> o_offset_word == $past(i_wr.data))
    else $error("offset word not stored");

  a_offset_applied: assert property (
    i_wr.en && i_wr.sel == SEL_OFFSET && o_gross_enable
    && signed'(i_wr.data) <= GP_LIMIT && signed'(i_wr.data) >= -GP_LIMIT
    |=> o_guide_point == signed'($past(i_wr.data)))
    else $error("offset not applied to guide point");

  a_accel_gate: assert property (
    i_wr.en && i_wr.sel == SEL_ACCEL && !i_wr.data[7]
    |=> $stable(o_accel))
    else $error("acceleration taken without enable");

  a_accel_taken: assert property (
    i_wr.en && i_wr.sel == SEL_ACCEL && i_wr.data[7]
    && i_wr.data[6:0] <= SETTING_MAX |=> o_accel == 7'($past(i_wr.data)))
    else $error("acceleration not taken");

  a_speed_taken: assert property (
    i_wr.en && i_wr.sel == SEL_SPEED && i_wr.data[15]
    && i_wr.data[14:8] <= SETTING_MAX
    |=> o_speed == 7'($past(i_wr.data) >> SPEED_VAL_LSB))
    else $error("speed not taken");

  c_auto_step: cover property (
    o_auto_mode ##1 $changed(o_guide_point));
  c_manual_jog: cover property (o_jog_left ##[1:20] o_jog_right);
  c_center: cover property (o_center_start);
  c_offset: cover property (o_gross_enable ##1 $changed(o_guide_point));

endmodule
